// [core/afe_status_config_registers.sv]
// Status, communication and configuration register bank of the analog front end.
// Assumes an APB master on ref_clk and converter ready pulses synchronous to ref_clk.
//
// How it works
// - Read increment field picks map, type, group or same-address wrapping.
// - Write increment bit wraps writes over writable map, else same address.
// - Idle ready pin drives high if float-select set, else floats.
// - Merge bit gives one ready pulse on the most lagging channel.
// - Checksum width bit selects 16-bit or 16-bit plus sixteen zeros.
// - Output width field selects 32 sign, 32 zero, 24 or 16 bit.
// - Communication checksum enable appends a checksum to every communication.
// - Alarm enabled and map checksum error holds ready pin low.
// - Writing the guard key password clears a latched alarm.
// - Alarm disabled: checksum still computed and readable, never signalled.
// - Per-channel ready flags read 1 idle, 0 when data ready.
// - Only a status register read or sys_rst returns a ready flag to 1.
// - Offset correction enable applies correction with no added delay.
// - Gain correction enable delays every ready pulse 24 modulator periods.
// - Noise shaping field selects noise_shaping_strength maximum, medium, minimum, off.
// - Bias field selects twice, nominal, 0.66 or half bias current.
// - Analog clock divider divides master clock by 1, 2, 4, 8.
// - Per-channel soft reset bits hold converters in reset.
// - Per-channel shutdown bits place converters in shutdown.
// - External reference select disables internal reference.
// - External clock select disables the crystal oscillator.
// - Map checksum recomputed continuously, stored every 14 modulator periods unless the guard register holds the key.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module afe_status_config_registers
(
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [2:0]           conv_ready,
   input  wire logic                 comm_step,
   input  wire logic                 comm_write,
   input  wire logic [4:0]           comm_addr,
   output logic [4:0]                comm_next_addr,
   output logic                      data_ready_output_o,
   output logic                      data_ready_output_oe,
   output logic                      analog_clk_en,
   output afe_regs_pkg::status_reg_t status_out,
   output afe_regs_pkg::cfg_zero_t   cfg_zero_out,
   output afe_regs_pkg::cfg_one_t    cfg_one_out,
   output logic                      internal_reference_enable,
   output logic                      crystal_osc_enable
);
   afe_regs_pkg::status_reg_t status_q;
   afe_regs_pkg::cfg_zero_t   cfg_zero_q;
   afe_regs_pkg::cfg_one_t    cfg_one_q;
   afe_regs_pkg::pin_state_t  pin_q;
   logic [7:0]                guard_q;
   logic [15:0]               map_checksum_value_q;
   logic                      alarm_q;
   logic [3:0]                crc_tick_q;
   logic [1:0]                pulse_cnt_q;
   logic [2:0]                pending_q;
   logic [2:0]                fire;
   logic [4:0]                gain_cnt_q [3];
   logic                      analog_master_clock_en;
   logic                      modulator_digital_clock_en;
   logic                      access;
   logic                      wr_en;
   logic                      rd_status;
   logic                      merged_fire;
   logic                      any_fire;
   logic [15:0]               crc_now;
   logic [23:0]               status_wr;
   // ==========================================================
   // Helper functions
   function automatic logic [23:0] lane_write(input logic [23:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb,
                                              input logic [23:0] mask);
      logic [23:0] merged;
      merged = old;
      for (int b = 0; b < 3; b++)
      begin
         if (strb[b])
            merged[b*8 +: 8] = wdata[b*8 +: 8];
      end
      return (old & ~mask) | (merged & mask);
   endfunction : lane_write
   function automatic logic [4:0] wrap_next(input logic [4:0] addr,
                                            input logic [4:0] lo,
                                            input logic [4:0] hi);
      return (addr >= hi) ? lo : 5'(addr + 5'h1);
   endfunction : wrap_next
   function automatic logic [15:0] crc16(input logic [71:0] msg);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 71; i >= 0; i--)
      begin
         c = (c[15] ^ msg[i]) ? ((c << 1) ^ afe_regs_pkg::CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc16
   function automatic logic [4:0] advance(input logic [4:0] addr,
                                          input logic       is_write,
                                          input logic [1:0] rmode,
                                          input logic       wmode);
      logic [4:0] next;
      next = addr;
      if (is_write)
      begin
         if (wmode)
            next = wrap_next(addr, afe_regs_pkg::TYPE_SPLIT, afe_regs_pkg::MAP_HI);
      end
      else
      begin
         unique case (afe_regs_pkg::read_incr_t'(rmode))
            afe_regs_pkg::READ_SAME: next = addr;
            afe_regs_pkg::READ_MAP:
               next = wrap_next(addr, afe_regs_pkg::MAP_LO, afe_regs_pkg::MAP_HI);
            afe_regs_pkg::READ_TYPE:
               next = (addr < afe_regs_pkg::TYPE_SPLIT)
                    ? wrap_next(addr, afe_regs_pkg::MAP_LO, 5'(afe_regs_pkg::TYPE_SPLIT - 5'h1))
                    : wrap_next(addr, afe_regs_pkg::TYPE_SPLIT, afe_regs_pkg::MAP_HI);
            afe_regs_pkg::READ_GROUP:
               if (addr <= afe_regs_pkg::GRP_DATA_HI)
                  next = wrap_next(addr, afe_regs_pkg::MAP_LO, afe_regs_pkg::GRP_DATA_HI);
               else if (addr <= afe_regs_pkg::GRP_CFG_HI)
                  next = wrap_next(addr, afe_regs_pkg::TYPE_SPLIT, afe_regs_pkg::GRP_CFG_HI);
               else if (addr <= afe_regs_pkg::GRP_CAL_HI)
                  next = wrap_next(addr, 5'(afe_regs_pkg::GRP_CFG_HI + 5'h1),
                                   afe_regs_pkg::GRP_CAL_HI);
               else
                  next = addr;
         endcase
      end
      return next;
   endfunction : advance
   // ==========================================================
   // Clock enables
   rate_divider u_analog_master_clock
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .in_en   (1'b1),
      .div_sel (cfg_zero_q.analog_clk_div),
      .out_en  (analog_master_clock_en)
   );
   rate_divider u_modulator_digital_clock
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .in_en   (analog_master_clock_en),
      .div_sel (afe_regs_pkg::DM_DIV_SEL),
      .out_en  (modulator_digital_clock_en)
   );
   // ==========================================================
   // APB slave, no wait states
   always_comb
   begin
      access    = psel && penable && pready;
      wr_en     = access && pwrite && (paddr[1:0] == 2'b00);
      rd_status = access && !pwrite && (paddr[7:2] == afe_regs_pkg::IDX_STATUS);
      status_wr = lane_write(status_q, pwdata, pstrb, afe_regs_pkg::STATUS_WMASK);
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            prdata <= 32'h0000_0000;
            unique case (paddr[7:2])
               afe_regs_pkg::IDX_STATUS:   prdata <= {8'h00, status_q};
               afe_regs_pkg::IDX_CFG_ZERO: prdata <= {8'h00, cfg_zero_q};
               afe_regs_pkg::IDX_CFG_ONE:  prdata <= {8'h00, cfg_one_q};
               afe_regs_pkg::IDX_GUARD:    prdata <= {8'h00, guard_q, map_checksum_value_q};
               default:                    pslverr <= 1'b1;
            endcase
            if (paddr[1:0] != 2'b00)
               pslverr <= 1'b1;
         end
      end
   end
   // ==========================================================
   // Configuration registers
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         status_q   <= afe_regs_pkg::STATUS_RST;
         cfg_zero_q <= afe_regs_pkg::CFG_ZERO_RST;
         cfg_one_q  <= afe_regs_pkg::CFG_ONE_RST;
      end
      else
      begin
         // A ready event wins over a status read in the same cycle.
         status_q.channel_ready_flags <=
            ~fire & (status_q.channel_ready_flags | {3{rd_status}});
         if (wr_en && paddr[7:2] == afe_regs_pkg::IDX_STATUS)
            status_q[23:3] <= status_wr[23:3];
         if (wr_en && paddr[7:2] == afe_regs_pkg::IDX_CFG_ZERO)
            cfg_zero_q <= lane_write(cfg_zero_q, pwdata, pstrb, afe_regs_pkg::CFG_ZERO_WMASK);
         if (wr_en && paddr[7:2] == afe_regs_pkg::IDX_CFG_ONE)
            cfg_one_q <= lane_write(cfg_one_q, pwdata, pstrb, afe_regs_pkg::CFG_ONE_WMASK);
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         analog_clk_en             <= 1'b0;
         status_out                <= afe_regs_pkg::STATUS_RST;
         cfg_zero_out              <= afe_regs_pkg::CFG_ZERO_RST;
         cfg_one_out               <= afe_regs_pkg::CFG_ONE_RST;
         internal_reference_enable <= 1'b1;
         crystal_osc_enable        <= 1'b0;
      end
      else
      begin
         analog_clk_en <= analog_master_clock_en;
         status_out   <= status_q;
         cfg_zero_out <= cfg_zero_q;
         cfg_one_out  <= cfg_one_q;
         internal_reference_enable <= !cfg_one_q.external_reference_select;
         crystal_osc_enable        <= !cfg_one_q.external_clock_select;
      end
   end
   // ==========================================================
   // Serial address counter
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         comm_next_addr <= afe_regs_pkg::MAP_LO;
      else if (comm_step)
         comm_next_addr <= advance(comm_addr, comm_write, status_q.read_incr,
                                   status_q.write_incr);
   end
   // ==========================================================
   // Ready events with optional gain-correction delay
   for (genvar ch = 0; ch < 3; ch++)
   begin : g_chan
      always_ff @(posedge ref_clk)
      begin
         if (sys_rst)
            gain_cnt_q[ch] <= 5'h00;
         else if (conv_ready[ch] && cfg_zero_q.gain_correction_enable)
            gain_cnt_q[ch] <= afe_regs_pkg::GAIN_DELAY_DM;
         else if (modulator_digital_clock_en && gain_cnt_q[ch] != 5'h00)
            gain_cnt_q[ch] <= gain_cnt_q[ch] - 5'h01;
      end
      always_comb
      begin
         fire[ch] = cfg_zero_q.gain_correction_enable
                  ? (modulator_digital_clock_en && gain_cnt_q[ch] == 5'h01)
                  : conv_ready[ch];
      end
   end
   // ==========================================================
   // Merged pulse: wait for every active channel, fire on the last one
   always_comb
   begin
      any_fire    = |fire;
      merged_fire = any_fire
                 && (&(pending_q | fire | cfg_one_q.channel_shutdown
                       | cfg_one_q.channel_soft_reset));
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         pending_q <= 3'h0;
      else if (!status_q.ready_pulse_merge || merged_fire)
         pending_q <= 3'h0;
      else
         pending_q <= pending_q | fire;
   end
   // ==========================================================
   // Register map checksum and alarm
   always_comb
   begin
      crc_now = crc16({status_q[23:3], 3'h0, cfg_zero_q, cfg_one_q});
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         guard_q <= afe_regs_pkg::GUARD_KEY;
      else if (wr_en && paddr[7:2] == afe_regs_pkg::IDX_GUARD && pstrb[2])
         guard_q <= pwdata[23:16];
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || guard_q == afe_regs_pkg::GUARD_KEY)
         crc_tick_q <= 4'h0;
      else if (modulator_digital_clock_en)
         crc_tick_q <= (crc_tick_q == afe_regs_pkg::MAP_CRC_DM - 4'h1) ? 4'h0
                     : crc_tick_q + 4'h1;
   end
   // The first stored value after unlocking is taken as the reference, so it never alarms.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || guard_q == afe_regs_pkg::GUARD_KEY)
      begin
         map_checksum_value_q <= 16'h0000;
         alarm_q              <= 1'b0;
      end
      else if (modulator_digital_clock_en && crc_tick_q == afe_regs_pkg::MAP_CRC_DM - 4'h1)
      begin
         map_checksum_value_q <= crc_now;
         if (status_q.map_alarm_enable && map_checksum_value_q != 16'h0000
             && crc_now != map_checksum_value_q)
            alarm_q <= 1'b1;
      end
   end
   // ==========================================================
   // Active-low data ready pin
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pin_q       <= afe_regs_pkg::PIN_IDLE;
         pulse_cnt_q <= 2'h0;
      end
      else if (alarm_q && status_q.map_alarm_enable)
         pin_q <= afe_regs_pkg::PIN_ALARM;
      else
      begin
         unique case (pin_q)
            afe_regs_pkg::PIN_IDLE, afe_regs_pkg::PIN_ALARM:
            begin
               pin_q <= afe_regs_pkg::PIN_IDLE;
               if (status_q.ready_pulse_merge ? merged_fire : any_fire)
               begin
                  pin_q       <= afe_regs_pkg::PIN_PULSE;
                  pulse_cnt_q <= afe_regs_pkg::READY_PULSE_DM;
               end
            end
            afe_regs_pkg::PIN_PULSE:
            begin
               if (modulator_digital_clock_en)
                  pulse_cnt_q <= pulse_cnt_q - 2'h1;
               if (modulator_digital_clock_en && pulse_cnt_q == 2'h1)
                  pin_q <= afe_regs_pkg::PIN_IDLE;
            end
            default:
               pin_q <= afe_regs_pkg::PIN_IDLE;
         endcase
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         data_ready_output_o  <= 1'b1;
         data_ready_output_oe <= 1'b0;
      end
      else
      begin
         data_ready_output_o  <= (pin_q == afe_regs_pkg::PIN_IDLE);
         data_ready_output_oe <= (pin_q != afe_regs_pkg::PIN_IDLE)
                                 || status_q.ready_idle_float_select;
      end
   end
endmodule : afe_status_config_registers

// [core/afe_regs_pkg.sv]
// Register layouts, reset values and timing counts for the front-end register bank.
// Assumes a single 200 MHz ref_clk domain and an APB master with 32-bit data.
package afe_regs_pkg;

   // ==========================================================
   // Register indexes (byte address is four times the index)
   localparam logic [5:0]  IDX_STATUS     = 6'h0c;
   localparam logic [5:0]  IDX_CFG_ZERO   = 6'h0d;
   localparam logic [5:0]  IDX_CFG_ONE    = 6'h0f;
   localparam logic [5:0]  IDX_GUARD      = 6'h1f;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [23:0] STATUS_RST     = 24'ha90007;
   localparam logic [23:0] CFG_ZERO_RST   = 24'h386050;
   localparam logic [23:0] CFG_ONE_RST    = 24'h000040;
   localparam logic [23:0] STATUS_WMASK   = 24'hffc000;
   localparam logic [23:0] CFG_ZERO_WMASK = 24'hffe0ff;
   localparam logic [23:0] CFG_ONE_WMASK  = 24'h0707c0;
   localparam logic [7:0]  GUARD_KEY      = 8'ha5;
   localparam logic [2:0]  FLAGS_IDLE     = 3'h7;

   // ==========================================================
   // Address map regions for the serial address counter
   localparam logic [4:0]  MAP_LO         = 5'h00;
   localparam logic [4:0]  MAP_HI         = 5'h1f;
   localparam logic [4:0]  TYPE_SPLIT     = 5'h08;
   localparam logic [4:0]  GRP_DATA_HI    = 5'h02;
   localparam logic [4:0]  GRP_CFG_HI     = 5'h0c;
   localparam logic [4:0]  GRP_CAL_HI     = 5'h14;

   // ==========================================================
   // Timing in modulator clock periods, modulator clock divide select and checksum polynomial
   localparam logic [4:0]  GAIN_DELAY_DM  = 5'd24;
   localparam logic [3:0]  MAP_CRC_DM     = 4'd14;
   localparam logic [1:0]  READY_PULSE_DM = 2'd1;
   localparam logic [1:0]  DM_DIV_SEL     = 2'b10;
   localparam logic [15:0] CRC_POLY       = 16'h8005;

   typedef enum logic [1:0] {
      READ_SAME  = 2'b00,
      READ_GROUP = 2'b01,
      READ_TYPE  = 2'b10,
      READ_MAP   = 2'b11
   } read_incr_t;

   typedef enum logic [1:0] {
      PIN_IDLE  = 2'b00,
      PIN_PULSE = 2'b01,
      PIN_ALARM = 2'b10
   } pin_state_t;

   typedef struct packed {
      logic [1:0]  read_incr;
      logic        write_incr;
      logic        ready_idle_float_select;
      logic        ready_pulse_merge;
      logic        comm_checksum_wide;
      logic [1:0]  data_width;
      logic        comm_checksum_enable;
      logic        map_alarm_enable;
      logic [10:0] unused;
      logic [2:0]  channel_ready_flags;
   } status_reg_t;

   typedef struct packed {
      logic        offset_correction_enable;
      logic        gain_correction_enable;
      logic [1:0]  noise_shaping_strength;
      logic [1:0]  bias_current_select;
      logic [1:0]  analog_clk_div;
      logic [2:0]  oversampling;
      logic [4:0]  unused;
      logic [7:0]  ref_trim;
   } cfg_zero_t;

   typedef struct packed {
      logic [4:0]  unused_hi;
      logic [2:0]  channel_soft_reset;
      logic [4:0]  unused_mid;
      logic [2:0]  channel_shutdown;
      logic        external_reference_select;
      logic        external_clock_select;
      logic [5:0]  unused_lo;
   } cfg_one_t;

endpackage : afe_regs_pkg

// [core/rate_divider.sv]
// Enable divider: passes one of every 1, 2, 4 or 8 input enable pulses.
// Assumes in_en is a one-cycle pulse or held high in the ref_clk domain.
`timescale 1ns/1ps
module rate_divider
(
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       in_en,
   input  wire logic [1:0] div_sel,
   output logic            out_en
);

   logic [2:0] count_q;
   logic [2:0] limit;

   // ==========================================================
   // Divide chain
   always_comb
   begin
      limit = 3'((4'd1 << div_sel) - 4'd1);
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         count_q <= 3'h0;
         out_en  <= 1'b0;
      end
      else
      begin
         out_en <= 1'b0;
         if (in_en)
         begin
            if (count_q >= limit)
            begin
               count_q <= 3'h0;
               out_en  <= 1'b1;
            end
            else
            begin
               count_q <= count_q + 3'h1;
            end
         end
      end
   end

endmodule : rate_divider

// [dv/afe_regs_monitor.sv]
// Checker on the ports of the front-end register bank.
// Assumes one ref_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/1ps
module afe_regs_monitor
(
   input wire logic                      ref_clk,
   input wire logic                      sys_rst,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic                      pready,
   input wire logic [2:0]                conv_ready,
   input wire logic                      comm_step,
   input wire logic                      comm_write,
   input wire logic [4:0]                comm_addr,
   input wire logic [4:0]                comm_next_addr,
   input wire logic                      data_ready_output_o,
   input wire logic                      data_ready_output_oe,
   input wire afe_regs_pkg::status_reg_t status_out,
   input wire afe_regs_pkg::cfg_zero_t   cfg_zero_out
);
   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   setup_answer_a: assert property (psel && !penable |=> pready)
      else $error("setup not answered");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   pin_low_driven_a: assert property (!data_ready_output_o |-> data_ready_output_oe)
      else $error("low pin not driven");
   // Gain correction delays the flag, so only the undelayed path is timed here.
   flag_clear_a: assert property (conv_ready != 3'h0 && !cfg_zero_out.gain_correction_enable
      |-> ##2 (status_out.channel_ready_flags & $past(conv_ready, 2)) == 3'h0)
      else $error("ready flag not cleared");
   flag_set_a: assert property (psel && penable && pready && !pwrite && paddr == 8'h30
      && conv_ready == 3'h0 && !cfg_zero_out.gain_correction_enable
      |-> ##2 status_out.channel_ready_flags == 3'h7)
      else $error("ready flags not rearmed");
   read_same_a: assert property (comm_step && !comm_write && status_out.read_incr == 2'b00
      |=> comm_next_addr == $past(comm_addr))
      else $error("read address moved");
   write_same_a: assert property (comm_step && comm_write && !status_out.write_incr
      |=> comm_next_addr == $past(comm_addr))
      else $error("write address moved");
   unused_zero_a: assert property (status_out.unused == 11'h000)
      else $error("unused status bits set");
   cover property (!data_ready_output_o);
   cover property (comm_step && comm_write);
   cover property (pready && pwrite);
endmodule : afe_regs_monitor

// [dv/far_side_model.sv]
// Model of the serial host engine and of the three converters.
// Assumes every request changes just after a rising ref_clk edge.
`timescale 1ns/1ps
module far_side_model
(
   input  wire logic  ref_clk,
   output logic [2:0] conv_ready = 3'h0,
   output logic       comm_step  = 1'b0,
   output logic       comm_write = 1'b0,
   output logic [4:0] comm_addr  = 5'h00
);
   // ==========================================================
   // Requests
   task automatic pulse(input logic [2:0] ch);
      @(posedge ref_clk);
      conv_ready <= ch;
      @(posedge ref_clk);
      conv_ready <= 3'h0;
   endtask : pulse
   // Released address lines are inverted so a stale value never looks valid.
   task automatic step(input logic [4:0] a, input logic w);
      @(posedge ref_clk);
      comm_step  <= 1'b1;
      comm_write <= w;
      comm_addr  <= a;
      @(posedge ref_clk);
      comm_step  <= 1'b0;
      comm_addr  <= ~a;
   endtask : step
endmodule : far_side_model

// [dv/tb_top.sv]
// Bench: APB register tests, converter events and ready pin timing.
// Assumes the package, the bank, the far-side model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic        comm_step, comm_write, analog_clk_en, crystal_osc_enable;
   logic        data_ready_output_o, data_ready_output_oe, internal_reference_enable;
   logic [2:0]  conv_ready;
   logic [3:0]  pstrb;
   logic [4:0]  comm_addr, comm_next_addr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   afe_regs_pkg::status_reg_t status_out;
   afe_regs_pkg::cfg_zero_t   cfg_zero_out;
   afe_regs_pkg::cfg_one_t    cfg_one_out;
   int          fail_count = 0, check_count = 0, n;
   afe_status_config_registers afe_status_config_registers_i (.*);
   far_side_model far_side_model_i (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string s, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1 && ++n < 50);
      fail_count += (n >= 50);
      r = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e, m);
      xfer(1'b0, a, 32'h0);
      chk(s, r & m, e);
   endtask : rd
   // Cycles from a ready event to the pin going low; 150 means no pulse.
   task automatic lat(input logic [2:0] ch);
      far_side_model_i.pulse(ch);
      n = 0;
      while (data_ready_output_o !== 1'b0 && n < 150)
      begin
         @(posedge ref_clk);
         n++;
      end
      repeat (30) @(posedge ref_clk);
   endtask : lat
   task automatic cstep(input logic [1:0] m, input logic w, wr, input logic [4:0] a, e);
      xfer(1'b1, 8'h30, {8'h0, m, w, 5'h01, 16'h0});
      far_side_model_i.step(a, wr);
      @(negedge ref_clk);
      chk("next", comm_next_addr, e);
   endtask : cstep
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // ==========================================================
   // Tests
   initial
   begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd("stat", 8'h30, 32'ha90007, '1);
      rd("cfg0", 8'h34, 32'h386050, '1);
      rd("cfg1", 8'h3c, 32'h000040, '1);
      rd("key", 8'h7c, 32'ha50000, 32'hff0000);
      rd("hole", 8'h08, 32'h0, '1);
      chk("err", err, 1'b1);
      far_side_model_i.pulse(3'b010);
      rd("ready", 8'h30, 32'ha90005, '1);
      rd("rearm", 8'h30, 32'ha90007, '1);
      xfer(1'b1, 8'h30, 32'hffffcfff);
      rd("stat", 8'h30, 32'hffc007, '1);
      chk("stat_out", status_out, 24'hffc007);
      xfer(1'b1, 8'h34, 32'hffffffff);
      rd("cfg0", 8'h34, 32'hffe0ff, '1);
      chk("cfg0_out", cfg_zero_out, 24'hffe0ff);
      xfer(1'b1, 8'h3c, 32'hffffffff);
      rd("cfg1", 8'h3c, 32'h0707c0, '1);
      chk("cfg1_out", cfg_one_out, 24'h0707c0);
      chk("refs", {internal_reference_enable, crystal_osc_enable}, 2'b00);
      xfer(1'b1, 8'h3c, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk("refs", {internal_reference_enable, crystal_osc_enable}, 2'b11);
      for (int i = 3; i >= 0; i--)
      begin
         xfer(1'b1, 8'h34, 32'h386050 | (i << 16));
         repeat (16) @(posedge ref_clk);
         n = 0;
         repeat (64) @(posedge ref_clk) n += analog_clk_en;
         chk("analog_master_clock", n, 64 >> i);
      end
      xfer(1'b1, 8'h30, 32'hb10000);
      repeat (4) @(posedge ref_clk);
      chk("idle", {data_ready_output_o, data_ready_output_oe}, 2'b11);
      lat(3'b001);
      chk("lat", n inside {[1:8]}, 1'b1);
      xfer(1'b1, 8'h34, 32'h786050);
      lat(3'b001);
      chk("gain", n inside {[90:110]}, 1'b1);
      xfer(1'b1, 8'h34, 32'h386050);
      xfer(1'b1, 8'h30, 32'ha90000);
      repeat (4) @(posedge ref_clk);
      chk("float", data_ready_output_oe, 1'b0);
      lat(3'b001);
      chk("merge", n, 150);
      lat(3'b110);
      chk("last", n inside {[1:8]}, 1'b1);
      cstep(2'b00, 1'b1, 1'b0, 5'h05, 5'h05);
      cstep(2'b01, 1'b1, 1'b0, 5'h0c, 5'h08);
      cstep(2'b10, 1'b1, 1'b0, 5'h1f, 5'h08);
      cstep(2'b11, 1'b1, 1'b0, 5'h1f, 5'h00);
      cstep(2'b10, 1'b1, 1'b1, 5'h1f, 5'h08);
      cstep(2'b10, 1'b0, 1'b1, 5'h10, 5'h10);
      xfer(1'b1, 8'h7c, 32'h0);
      repeat (150) @(posedge ref_clk);
      xfer(1'b0, 8'h7c, 32'h0);
      chk("crc", r[15:0] != 16'h0, 1'b1);
      xfer(1'b1, 8'h3c, 32'h000100);
      repeat (150) @(posedge ref_clk);
      chk("quiet", data_ready_output_o, 1'b1);
      xfer(1'b1, 8'h30, 32'ha14000);
      repeat (150) @(posedge ref_clk);
      chk("alarm", {data_ready_output_o, data_ready_output_oe}, 2'b01);
      xfer(1'b1, 8'h7c, 32'ha50000);
      repeat (4) @(posedge ref_clk);
      chk("clear", data_ready_output_o, 1'b1);
      conclude();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end
endmodule : tb_top
bind afe_status_config_registers afe_regs_monitor afe_regs_monitor_i (.*);
